/* core/drc_params.svh */
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

// register indices (byte address = 4 * index)
`define DRC_REG_CTRL 4'h0
`define DRC_REG_TIMING 4'h1
`define DRC_REG_SHADOW 4'h2
`define DRC_REG_SHADOW_HI 4'he
`define DRC_REG_NCWP_BASE 4'h3
`define DRC_REG_REGION_BASE 4'h9
`define DRC_REG_REGION_LIMIT 4'ha
`define DRC_REG_REGION_CFG 4'hb
`define DRC_REG_STATUS 4'hc
`define DRC_REG_BANKCFG 4'hd
`define DRC_NCWP_COUNT 6

// control register fields
`define DRC_CTRL_MODE_LSB 0
`define DRC_CTRL_SLOW_BIT 2
`define DRC_CTRL_CBR_BIT 3
`define DRC_CTRL_PAGE_BIT 4
`define DRC_CTRL_ILV_LSB 5

// reset values
`define DRC_CTRL_RESET 32'h0000_0000
`define DRC_TIMING_RESET 32'h0000_0222
`define DRC_BANKCFG_RESET 32'h0000_0001

// timing in nanoseconds and clock cycles at the 50 MHz clock
`define DRC_CLK_PERIOD_NS 20
`define DRC_REF_NS 15625
`define DRC_SLOW_REF_NS 125000
`define DRC_REF_CYCLES (`DRC_REF_NS / `DRC_CLK_PERIOD_NS)
`define DRC_SLOW_REF_CYCLES (`DRC_SLOW_REF_NS / `DRC_CLK_PERIOD_NS)
`define DRC_SLOT_REF_CYCLES 8
`define DRC_BANK_STAGGER 2

// shadow window A0000h..FFFFFh in 16 KB segments
`define DRC_SHADOW_BASE_SEG 6'h28
`define DRC_SHADOW_SEGS 24
`define DRC_FASTBUS_DIV 2
`define DRC_SLOWBUS_DIV 4

`endif

/* core/drc_pkg.sv */
package drc_pkg;
  typedef enum logic [1:0] {
    DRC_REF_SYNC = 2'h0,
    DRC_REF_ASYNC = 2'h1,
    DRC_REF_DECOUPLED = 2'h2
  } drc_ref_mode_t;

  typedef enum logic [1:0] {
    DRC_SH_ROM = 2'h0,
    DRC_SH_DRAM = 2'h1,
    DRC_SH_RDRAM_WSLOT = 2'h2,
    DRC_SH_RROM_WDRAM = 2'h3
  } drc_shadow_t;

  typedef enum logic [1:0] {
    DRC_RG_DRAM = 2'h0,
    DRC_RG_ISA = 2'h1,
    DRC_RG_LOCAL = 2'h2
  } drc_region_t;

  typedef enum logic [2:0] {
    DRC_ST_IDLE = 3'b000,
    DRC_ST_PRE = 3'b001,
    DRC_ST_RAS = 3'b011,
    DRC_ST_CAS = 3'b010,
    DRC_ST_DONE = 3'b110,
    DRC_ST_REF = 3'b111
  } drc_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic master;
    logic [25:0] addr;
    logic [31:0] data;
  } drc_cycle_t;

  typedef struct packed {
    logic toSlot;
    logic toLocal;
    logic toDram;
    logic cacheable;
    logic writeBlock;
    logic fastBus;
  } drc_route_t;
endpackage

/* core/dram_refresh_and_region_control.sv */
`include "drc_params.svh"
// How it works
// [R01] three refresh coupling modes selectable
// [R02] sync: both refreshes together, stall cycles
// [R03] async: start together, release after on-board
// [R04] decoupled: own slot counter, DRAM refresh idle
// [R05] intervals 15.625 us and 125 us
// [R06] bank row strobes staggered during refresh
// [R07] column-before-row refresh as option
// [R08] shadow control per 16 KB, A0000h-FFFFFh
// [R09] four routings per shadow segment
// [R10] six registers: non-cacheable, write-protect
// [R11] programmable DRAM/ISA/local region, three granularities
// [R12] fast-bus region uses faster slot clock
// [R13] local bus claim input disclaims cycle
// [R14] DMA/master hitting range runs local cycle
// [R15] check parity on DRAM reads
// [R16] no parity on processor DRAM writes
// [R17] generate parity on DMA/master DRAM writes
// [R18] programmable precharge, row-column, column width
// [R19] four banks, 256K/1M/4M, 64 MB; no device size select, memAddr always takes row addr[25:14], column addr[11:2]
// [R20] page mode and up to four-way interleave
// [R21] cache miss input gates memory cycle
// [R22] burst ready only for local DRAM accesses
// [R23] refresh request held pending until served
module dram_refresh_and_region_control
  import drc_pkg::*;
#(
  parameter int REF_CYCLES = `DRC_REF_CYCLES,
  parameter int SLOW_REF_CYCLES = `DRC_SLOW_REF_CYCLES,
  parameter int BANKS = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire drc_cycle_t cpuCycle,
  input wire logic local_bus_claim_in,
  input wire logic cacheMiss,
  input wire logic [3:0] dramParIn,
  output logic burst_ready,
  output logic [3:0] rasN,
  output logic [3:0] casN,
  output logic [11:0] memAddr,
  output logic [3:0] dramParOut,
  output logic dramParOe,
  output logic parityError,
  output logic slotRefreshN,
  output logic slotClk,
  output drc_route_t routeOut,
  output logic localCycleStart
);
  if (BANKS < 1 || BANKS > 4 || REF_CYCLES < 2 || SLOW_REF_CYCLES < 2) begin : g_bad_params
    $error("dram_refresh_and_region_control: bad parameters");
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrlReg, timingReg, bankCfgReg, shadowReg, shadowHiReg;
  logic [31:0] ncwpReg [`DRC_NCWP_COUNT];
  logic [31:0] regionBase, regionLimit, regionCfg;
  logic [31:0] statusWord;
  drc_state_t state;
  logic [3:0] staggerCnt;
  logic dramRefPend, slotRefPend, slotBusy, hold;

  drc_ref_mode_t refMode;
  logic slowRef, cbrRef, pageMode;
  logic [1:0] interleave;
  assign refMode = drc_ref_mode_t'(ctrlReg[`DRC_CTRL_MODE_LSB +: 2]); // [R01]
  assign slowRef = ctrlReg[`DRC_CTRL_SLOW_BIT];
  assign cbrRef = ctrlReg[`DRC_CTRL_CBR_BIT];
  assign pageMode = ctrlReg[`DRC_CTRL_PAGE_BIT];
  assign interleave = ctrlReg[`DRC_CTRL_ILV_LSB +: 2];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrlReg <= `DRC_CTRL_RESET;
      timingReg <= `DRC_TIMING_RESET; // [R18]
      bankCfgReg <= `DRC_BANKCFG_RESET;
      shadowReg <= 32'h0000_0000;
      shadowHiReg <= 32'h0000_0000;
      regionBase <= 32'h0000_0000;
      regionLimit <= 32'h0000_0000;
      regionCfg <= 32'h0000_0000;
      for (int i = 0; i < `DRC_NCWP_COUNT; i++) ncwpReg[i] <= 32'h0000_0000;
    end else if (regWr) begin
      case (regAddr)
        `DRC_REG_CTRL: ctrlReg <= regWrData;
        `DRC_REG_TIMING: timingReg <= regWrData;
        `DRC_REG_SHADOW: shadowReg <= regWrData;
        `DRC_REG_SHADOW_HI: shadowHiReg <= regWrData;
        `DRC_REG_REGION_BASE: regionBase <= regWrData;
        `DRC_REG_REGION_LIMIT: regionLimit <= regWrData;
        `DRC_REG_REGION_CFG: regionCfg <= regWrData;
        `DRC_REG_BANKCFG: bankCfgReg <= regWrData;
        default: begin
          if (regAddr >= `DRC_REG_NCWP_BASE && regAddr < `DRC_REG_REGION_BASE)
            ncwpReg[3'(regAddr - `DRC_REG_NCWP_BASE)] <= regWrData; // [R10]
        end
      endcase
    end
  end

  assign statusWord = {20'h0, parityError, hold, slotBusy, slotRefPend, dramRefPend, 4'h0, state};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        `DRC_REG_CTRL: regRdData <= ctrlReg;
        `DRC_REG_TIMING: regRdData <= timingReg;
        `DRC_REG_SHADOW: regRdData <= shadowReg;
        `DRC_REG_SHADOW_HI: regRdData <= shadowHiReg;
        `DRC_REG_REGION_BASE: regRdData <= regionBase;
        `DRC_REG_REGION_LIMIT: regRdData <= regionLimit;
        `DRC_REG_REGION_CFG: regRdData <= regionCfg;
        `DRC_REG_STATUS: regRdData <= statusWord;
        `DRC_REG_BANKCFG: regRdData <= bankCfgReg;
        default: begin
          if (regAddr >= `DRC_REG_NCWP_BASE && regAddr < `DRC_REG_REGION_BASE)
            regRdData <= ncwpReg[3'(regAddr - `DRC_REG_NCWP_BASE)];
          else
            regRdData <= 32'h0000_0000;
        end
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [5:0] seg16k;
  logic inShadow, inRegion;
  logic [4:0] shIdx;
  drc_shadow_t shSel;
  logic [15:0] ncwpFlags;
  logic [25:0] granMask;
  drc_route_t next_route;
  assign seg16k = cpuCycle.addr[19:14];
  assign inShadow = cpuCycle.addr[25:20] == 6'h00 && seg16k >= `DRC_SHADOW_BASE_SEG; // [R08]
  assign shIdx = 5'(seg16k - `DRC_SHADOW_BASE_SEG);
  assign shSel = drc_shadow_t'(shIdx[4] ? shadowHiReg[{shIdx[3:0], 1'b0} +: 2]
    : shadowReg[{shIdx[3:0], 1'b0} +: 2]); // [R08]
  assign ncwpFlags = ncwpReg[3'(shIdx >> 2)][15:0];

  always_comb begin
    case (regionCfg[1:0])
      2'h0: granMask = 26'h3ff_f800; // [R11]
      2'h1: granMask = 26'h3ff_0000;
      default: granMask = 26'h3f0_0000;
    endcase
  end
  assign inRegion = regionCfg[4] && (cpuCycle.addr & granMask) >= (regionBase[25:0] & granMask)
    && (cpuCycle.addr & granMask) <= (regionLimit[25:0] & granMask);

  always_comb begin
    next_route = '0;
    next_route.toDram = 1'b1;
    next_route.cacheable = 1'b1;
    if (inShadow) begin
      case (shSel) // [R09]
        DRC_SH_ROM: next_route.toDram = 1'b0;
        DRC_SH_DRAM: next_route.toDram = 1'b1;
        DRC_SH_RDRAM_WSLOT: next_route.toDram = !cpuCycle.write;
        DRC_SH_RROM_WDRAM: next_route.toDram = cpuCycle.write;
        default: next_route.toDram = 1'b0;
      endcase
      next_route.cacheable = !ncwpFlags[{shIdx[1:0], 2'b00}]; // [R10]
      next_route.writeBlock = cpuCycle.write && ncwpFlags[{shIdx[1:0], 2'b01}];
    end else if (inRegion) begin
      next_route.toDram = drc_region_t'(regionCfg[3:2]) == DRC_RG_DRAM;
      next_route.toLocal = drc_region_t'(regionCfg[3:2]) == DRC_RG_LOCAL;
      next_route.cacheable = regionCfg[5];
      next_route.fastBus = regionCfg[6]; // [R12]
    end
    next_route.toSlot = !next_route.toDram && !next_route.toLocal;
  end

  // ----------------------------------------------------------------
  // refresh timers
  // ----------------------------------------------------------------
  logic [17:0] refCnt, slotCnt;
  logic [17:0] refLimit;
  logic refTick, slotTick, refStart, dramRefDone, slotRefDone;
  logic [3:0] slotRefCnt;
  assign refLimit = slowRef ? 18'(SLOW_REF_CYCLES - 1) : 18'(REF_CYCLES - 1); // [R05]
  assign refTick = refCnt == refLimit;
  assign slotTick = slotCnt == 18'(REF_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (rst || refTick) refCnt <= 18'h0;
    else refCnt <= refCnt + 18'h1; // [R23]
  end

  // decoupled mode keeps a separate slot refresh counter
  always_ff @(posedge sys_clk) begin
    if (rst || slotTick) slotCnt <= 18'h0;
    else slotCnt <= slotCnt + 18'h1; // [R04]
  end

  assign refStart = state == DRC_ST_IDLE && dramRefPend && (refMode != DRC_REF_DECOUPLED || !cpuCycle.valid)
    && (refMode != DRC_REF_SYNC || !slotBusy); // [R04]
  assign dramRefDone = state == DRC_ST_REF && staggerCnt == 4'(`DRC_BANK_STAGGER * BANKS + 1);
  assign slotRefDone = slotBusy && slotRefCnt == 4'(`DRC_SLOT_REF_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (rst) dramRefPend <= 1'b0;
    else if (refTick) dramRefPend <= 1'b1; // [R23]
    else if (refStart) dramRefPend <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) slotRefPend <= 1'b0;
    else if (refMode == DRC_REF_DECOUPLED ? slotTick : refTick) slotRefPend <= 1'b1;
    else if (!slotBusy && (refMode == DRC_REF_DECOUPLED || refStart)) slotRefPend <= 1'b0; // [R03]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slotBusy <= 1'b0;
      slotRefCnt <= 4'h0;
    end else if (slotBusy) begin
      slotRefCnt <= slotRefCnt + 4'h1;
      if (slotRefDone) slotBusy <= 1'b0;
    end else if (slotRefPend && (refMode == DRC_REF_DECOUPLED || refStart)) begin
      slotBusy <= 1'b1;
      slotRefCnt <= 4'h0;
    end
  end

  // sync mode holds memory cycles until both refreshes end
  always_ff @(posedge sys_clk) begin
    if (rst) hold <= 1'b0;
    else if (refStart) hold <= 1'b1;
    else if (refMode == DRC_REF_SYNC) hold <= hold && !(state == DRC_ST_IDLE && !slotBusy); // [R02]
    else if (dramRefDone) hold <= 1'b0; // [R03]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) slotRefreshN <= 1'b1;
    else slotRefreshN <= !slotBusy;
  end

  // ----------------------------------------------------------------
  // slot bus clock enable
  // ----------------------------------------------------------------
  logic [1:0] slotDiv;
  always_ff @(posedge sys_clk) begin
    if (rst) slotDiv <= 2'h0;
    else if (slotDiv >= 2'(routeOut.fastBus ? `DRC_FASTBUS_DIV - 1 : `DRC_SLOWBUS_DIV - 1)) slotDiv <= 2'h0; // [R12]
    else slotDiv <= slotDiv + 2'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) slotClk <= 1'b0;
    else if (slotDiv == 2'h0) slotClk <= !slotClk;
  end

  // ----------------------------------------------------------------
  // dram cycle sequencer
  // ----------------------------------------------------------------
  logic [3:0] phaseCnt;
  logic [3:0] phaseLen;
  logic dramHit, accept, pageHit;
  logic [1:0] bankSel;
  logic [11:0] openRow;
  logic rowOpen;
  drc_cycle_t cur;
  assign dramHit = next_route.toDram && !next_route.writeBlock;
  // a claimed cycle or a cache-hit read is left alone
  assign accept = state == DRC_ST_IDLE && cpuCycle.valid && !hold && !refStart
    && !local_bus_claim_in && (cacheMiss || cpuCycle.write) && dramHit; // [R13] [R21]
  assign bankSel = interleave == 2'h2 ? cur.addr[3:2] : interleave == 2'h1 ? {1'b0, cur.addr[2]}
    : 2'(cur.addr[25:24] % bankCfgReg[2:0]); // [R19] [R20]
  assign pageHit = pageMode && rowOpen && openRow == cpuCycle.addr[25:14];

  always_comb begin
    case (state)
      DRC_ST_PRE: phaseLen = timingReg[3:0]; // [R18]
      DRC_ST_RAS: phaseLen = timingReg[7:4];
      DRC_ST_CAS: phaseLen = timingReg[11:8];
      default: phaseLen = 4'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= DRC_ST_IDLE;
      phaseCnt <= 4'h0;
      staggerCnt <= 4'h0;
      cur <= '0;
      rowOpen <= 1'b0;
      openRow <= 12'h0;
    end else begin
      phaseCnt <= phaseCnt + 4'h1;
      case (state)
        DRC_ST_IDLE: begin
          phaseCnt <= 4'h0;
          staggerCnt <= 4'h0;
          if (refStart) begin
            state <= DRC_ST_REF;
            rowOpen <= 1'b0;
          end else if (accept) begin
            cur <= cpuCycle;
            state <= pageHit ? DRC_ST_CAS : DRC_ST_PRE; // [R20]
          end
        end
        DRC_ST_PRE: if (phaseCnt >= phaseLen) begin
          state <= DRC_ST_RAS;
          phaseCnt <= 4'h0;
        end
        DRC_ST_RAS: if (phaseCnt >= phaseLen) begin
          state <= DRC_ST_CAS;
          phaseCnt <= 4'h0;
          rowOpen <= 1'b1;
          openRow <= cur.addr[25:14];
        end
        DRC_ST_CAS: if (phaseCnt >= phaseLen) state <= DRC_ST_DONE;
        DRC_ST_DONE: state <= DRC_ST_IDLE;
        DRC_ST_REF: begin
          staggerCnt <= staggerCnt + 4'h1;
          if (dramRefDone) state <= DRC_ST_IDLE;
        end
        default: state <= DRC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // strobes, address, ready, parity
  // ----------------------------------------------------------------
  logic [1:0] curBank;
  assign curBank = bankSel;
  for (genvar b = 0; b < 4; b++) begin : g_bank
    logic refRas;
    // each bank drops its row strobe a few cycles after the previous one
    assign refRas = staggerCnt > 4'(b * `DRC_BANK_STAGGER) && b < BANKS; // [R06]
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        rasN[b] <= 1'b1;
        casN[b] <= 1'b1;
      end else if (state == DRC_ST_REF) begin
        rasN[b] <= !(refRas && !dramRefDone);
        casN[b] <= !(cbrRef && b < BANKS && !dramRefDone); // [R07]
      end else begin
        rasN[b] <= !((state == DRC_ST_RAS || state == DRC_ST_CAS) && curBank == 2'(b));
        casN[b] <= !(state == DRC_ST_CAS);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) memAddr <= 12'h0;
    else memAddr <= state == DRC_ST_CAS ? {2'h0, cur.addr[11:2]} : cur.addr[25:14];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) burst_ready <= 1'b0;
    else burst_ready <= state == DRC_ST_CAS && phaseCnt >= phaseLen && !cur.master; // [R22]
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dramParOut <= 4'h0;
      dramParOe <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) dramParOut[i] <= ~^cur.data[i*8 +: 8];
      dramParOe <= state == DRC_ST_CAS && cur.write && cur.master; // [R16] [R17]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) parityError <= 1'b0;
    else if (state == DRC_ST_CAS && phaseCnt >= phaseLen && !cur.write) begin
      parityError <= 1'b0;
      for (int i = 0; i < 4; i++)
        if ((~^cpuCycle.data[i*8 +: 8]) != dramParIn[i]) parityError <= 1'b1; // [R15]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      routeOut <= '0;
      localCycleStart <= 1'b0;
    end else begin
      routeOut <= cpuCycle.valid ? next_route : routeOut;
      localCycleStart <= cpuCycle.valid && cpuCycle.master && next_route.toLocal; // [R14]
    end
  end
endmodule

/* sim/drc_monitor.sv */
module drc_monitor
  import drc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire drc_cycle_t cpuCycle,
  input wire logic local_bus_claim_in,
  input wire logic cacheMiss,
  input wire logic burst_ready,
  input wire logic [3:0] rasN,
  input wire logic dramParOe,
  input wire logic slotRefreshN,
  input wire logic slotClk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // port checks
  // ----------------------------------------
  default clocking mcb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_ready_one_cycle: assert property (burst_ready |=> !burst_ready)
    else $error("burst ready held longer than one cycle");
  a_ready_cpu_only: assert property (burst_ready |-> cpuCycle.valid && !cpuCycle.master)
    else $error("burst ready without a processor cycle");
  a_claim_blocks_ready: assert property (burst_ready |-> !local_bus_claim_in)
    else $error("burst ready on a claimed cycle");
  a_miss_gates_read: assert property (burst_ready |-> cpuCycle.write || cacheMiss)
    else $error("burst ready on a cache hit read");
  a_cpu_no_parity: assert property (cpuCycle.valid && !cpuCycle.master && $past(cpuCycle.valid)
    && !$past(cpuCycle.master) |-> !dramParOe)
    else $error("parity driven during a processor cycle");
  a_ras_staggered: assert property ($countones(~rasN & $past(rasN)) <= 1)
    else $error("two row strobes fell in one cycle");
  a_slot_ref_len: assert property ($fell(slotRefreshN) |-> !slotRefreshN [*8] ##1 slotRefreshN)
    else $error("slot refresh length not eight cycles");
  a_slot_clk_hold: assert property ($changed(slotClk) |=> $stable(slotClk))
    else $error("slot clock toggled in consecutive cycles");
  c_ready_seen: cover property (burst_ready);
endmodule

/* sim/drc_dram_model.sv */
module drc_dram_model (
  input wire logic sys_clk,
  input wire logic [3:0] casN,
  input wire logic [31:0] rdData,
  input wire logic badPar,
  output logic [3:0] dramParIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // parity returned by the arrays
  // ----------------------------------------
  logic [3:0] lastPar = 4'h0;
  logic [3:0] oddPar;

  assign oddPar = {~^rdData[31:24], ~^rdData[23:16], ~^rdData[15:8], ~^rdData[7:0]};
  // released lines show a changing pattern, never the last value
  assign dramParIn = (&casN) ? ~lastPar : oddPar ^ {4{badPar}};

  always @(posedge sys_clk) begin
    lastPar <= dramParIn;
  end
endmodule

/* sim/testbench.sv */
`include "drc_params.svh"
`define CHK(nm, e, g) begin totalChecks++; if ((e) !== (g)) begin nMismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module testbench
  import drc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REF = 40;
  localparam int SLOW = 100;
  localparam logic [25:0] ADR = 26'h0001000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  drc_cycle_t cpuCycle = '0;
  logic local_bus_claim_in = 1'b0;
  logic cacheMiss = 1'b0;
  logic badPar = 1'b0;
  logic [3:0] dramParIn, rasN, casN, dramParOut;
  logic [31:0] regRdData;
  logic [11:0] memAddr;
  logic burst_ready, dramParOe, parityError, slotRefreshN, slotClk, localCycleStart;
  drc_route_t routeOut, rtSeen;
  logic rdy, oeSeen, rdyInRef, cbrSeen, lcsSeen;
  logic [3:0] parSeen;
  int nMismatch = 0;
  int totalChecks = 0;

  always #10 sys_clk = ~sys_clk;

  dram_refresh_and_region_control #(.REF_CYCLES(REF), .SLOW_REF_CYCLES(SLOW), .BANKS(4))
    dram_refresh_and_region_control_inst (.sys_clk, .rst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .cpuCycle, .local_bus_claim_in, .cacheMiss, .dramParIn, .burst_ready, .rasN, .casN,
    .memAddr, .dramParOut, .dramParOe, .parityError, .slotRefreshN, .slotClk, .routeOut, .localCycleStart);
  drc_dram_model drc_dram_model_inst (.sys_clk, .casN, .rdData(cpuCycle.data), .badPar, .dramParIn);

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic regW(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic regR(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    v = regRdData;
  endtask

  task automatic runCycle(input logic wr, input logic ms, input logic cl, input logic miss,
    input logic [25:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    cpuCycle <= '{1'b1, wr, ms, a, d};
    local_bus_claim_in <= cl;
    cacheMiss <= miss;
    rdy = 0;
    oeSeen = 0;
    rdyInRef = 0;
    lcsSeen = 0;
    for (i = 0; i < 60 && !rdy; i++) begin
      @(posedge sys_clk);
      #1;
      rtSeen = routeOut;
      if (localCycleStart === 1'b1) lcsSeen = 1;
      if (dramParOe === 1'b1) begin
        oeSeen = 1;
        parSeen = dramParOut;
      end
      if (burst_ready === 1'b1) begin
        rdy = 1;
        rdyInRef = !slotRefreshN;
      end
    end
    @(posedge sys_clk);
    cpuCycle.valid <= 1'b0;
    local_bus_claim_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic refGap(input logic [31:0] ctrl, output int gap);
    int i, n, t0;
    logic p;
    regW(`DRC_REG_CTRL, ctrl);
    p = 0;
    n = 0;
    t0 = 0;
    gap = -1;
    for (i = 0; i < 4 * SLOW && n < 2; i++) begin
      @(posedge sys_clk);
      #1;
      if (casN !== 4'hf && rasN === 4'hf) cbrSeen = 1;
      if (p === 1'b1 && slotRefreshN === 1'b0) begin
        if (n == 1) gap = i - t0;
        t0 = i;
        n++;
      end
      p = slotRefreshN;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testRegs;
    logic [31:0] v;
    regR(`DRC_REG_CTRL, v);
    `CHK("ctrl", `DRC_CTRL_RESET, v)
    regR(`DRC_REG_TIMING, v);
    `CHK("timing", `DRC_TIMING_RESET, v)
    regR(`DRC_REG_BANKCFG, v);
    `CHK("bankcfg", `DRC_BANKCFG_RESET, v)
    regW(`DRC_REG_TIMING, 32'h0000_0333);
    regR(`DRC_REG_TIMING, v);
    `CHK("timing", 32'h0000_0333, v)
    for (int k = 0; k < `DRC_NCWP_COUNT; k++) regW(4'(`DRC_REG_NCWP_BASE + k), 32'((k % 4) * 'h1111 ^ 'h0123));
    for (int k = 0; k < `DRC_NCWP_COUNT; k++) begin
      regR(4'(`DRC_REG_NCWP_BASE + k), v);
      `CHK("ncwp", 32'((k % 4) * 'h1111 ^ 'h0123), v)
    end
    regW(4'hf, 32'hffff_ffff);
    regR(4'hf, v);
    `CHK("unmapped", 32'h0, v)
  endtask

  task automatic testShadow;
    logic dr;
    for (int m = 0; m < 4; m++) begin
      regW(`DRC_REG_SHADOW, 32'(m));
      for (int w = 0; w < 2; w++) begin
        runCycle(w[0], 1'b0, 1'b0, 1'b1, 26'h00a0000, 32'h0);
        dr = w ? (m == 1 || m == 3) : (m == 1 || m == 2);
        `CHK("toDram", dr, rtSeen.toDram)
        `CHK("toSlot", !dr, rtSeen.toSlot)
        `CHK("wProtect", w[0], rtSeen.writeBlock)
        `CHK("nonCache", 1'b0, rtSeen.cacheable)
        `CHK("ready", dr && !w, rdy)
      end
    end
    regW(`DRC_REG_SHADOW, 32'h0);
    regW(`DRC_REG_SHADOW_HI, 32'h1 << 14);
    runCycle(1'b0, 1'b0, 1'b0, 1'b1, 26'h00fc000, 32'h0);
    `CHK("topSeg", 1'b1, rtSeen.toDram)
    runCycle(1'b0, 1'b0, 1'b0, 1'b1, 26'h00f8000, 32'h0);
    `CHK("pairSeg", 1'b0, rtSeen.toDram)
    regW(`DRC_REG_SHADOW_HI, 32'h0);
  endtask

  task automatic testRegion;
    regW(`DRC_REG_REGION_BASE, 32'h0020_0000);
    regW(`DRC_REG_REGION_LIMIT, 32'h0020_0000);
    regW(`DRC_REG_REGION_CFG, 32'h0000_005a);
    runCycle(1'b0, 1'b1, 1'b0, 1'b1, 26'h0200000, 32'h0);
    `CHK("toLocal", 1'b1, rtSeen.toLocal)
    `CHK("fastBus", 1'b1, rtSeen.fastBus)
    `CHK("localStart", 1'b1, lcsSeen)
    `CHK("localReady", 1'b0, rdy)
    regW(`DRC_REG_REGION_CFG, 32'h0000_0036);
    runCycle(1'b0, 1'b0, 1'b0, 1'b1, 26'h0200000, 32'h0);
    `CHK("isaSlot", 1'b1, rtSeen.toSlot)
    `CHK("isaCache", 1'b1, rtSeen.cacheable)
    `CHK("cpuStart", 1'b0, lcsSeen)
    `CHK("isaReady", 1'b0, rdy)
    regW(`DRC_REG_REGION_CFG, 32'h0);
  endtask

  task automatic testAccess;
    runCycle(1'b0, 1'b0, 1'b0, 1'b0, ADR, 32'h8421_5aa5);
    `CHK("hitRead", 1'b0, rdy)
    runCycle(1'b1, 1'b0, 1'b0, 1'b0, ADR, 32'h8421_5aa5);
    `CHK("write", 1'b1, rdy)
    `CHK("cpuParOe", 1'b0, oeSeen)
    runCycle(1'b0, 1'b0, 1'b1, 1'b1, ADR, 32'h8421_5aa5);
    `CHK("claimed", 1'b0, rdy)
    for (int k = 0; k < 3; k++) begin
      badPar <= (k == 1);
      runCycle(1'b0, 1'b0, 1'b0, 1'b1, ADR, 32'h8421_5aa5);
      `CHK("parityError", k == 1, parityError)
    end
    badPar <= 1'b0;
    runCycle(1'b1, 1'b1, 1'b0, 1'b0, ADR, 32'h0103_070f);
    `CHK("masterParOe", 1'b1, oeSeen)
    `CHK("masterPar", 4'h5, parSeen)
    `CHK("masterReady", 1'b0, rdy)
  endtask

  task automatic testRefresh;
    int g;
    regW(`DRC_REG_BANKCFG, 32'h4);
    cbrSeen = 0;
    refGap(32'h0, g);
    `CHK("syncGap", REF, g)
    `CHK("noCbr", 1'b0, cbrSeen)
    runCycle(1'b1, 1'b0, 1'b0, 1'b1, ADR, 32'h0);
    `CHK("syncStall", 1'b0, rdyInRef)
    `CHK("syncReady", 1'b1, rdy)
    refGap(32'h1, g);
    `CHK("asyncGap", REF, g)
    refGap(32'h2, g);
    `CHK("decoupledGap", REF, g)
    refGap(32'h4, g);
    `CHK("slowGap", SLOW, g)
    cbrSeen = 0;
    refGap(32'h8, g);
    `CHK("cbr", 1'b1, cbrSeen)
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    testRegs;
    testShadow;
    testAccess;
    testRegion;
    testRefresh;
    conclude;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    nMismatch++;
    conclude;
  end
endmodule

bind dram_refresh_and_region_control drc_monitor drc_monitor_inst (.sys_clk, .rst, .cpuCycle,
  .local_bus_claim_in, .cacheMiss, .burst_ready, .rasN, .dramParOe, .slotRefreshN, .slotClk);
